//--- rtl/rssx_exec.sv
/*
 * Execution of rotate-right-no-carry, set-all-ones, sleep and
 * subtract-reg-from-acc-borrow over one four-phase instruction cycle.
 * Assumes data memory returns read data in the cycle after the read
 * strobe, and that fetch presents the instruction during the decode phase.
 */
`default_nettype none

// Contract
// RULE1 - Rotate right no carry moves each bit one place down, bit 0 into bit 7, sets only N and Z.
// RULE2 - Destination bit 0 sends the result to the accumulator, 1 writes the file register.
// RULE3 - Bank bit 0 uses the quick-access bank and ignores the bank select register.
// RULE4 - Bank bit 1 forms the bank from the bank select register for file instructions.
// RULE5 - Bank bit 0 with extended set on and address up to 95 uses indexed literal offset.
// RULE6 - Set all ones writes ff to the addressed file register and touches no flag.
// RULE7 - Sleep clears the power down flag and sets the time out flag.
// RULE8 - Sleep clears the watchdog counter to 00 and clears its postscaler.
// RULE9 - Sleep enters low power with the oscillator stopped in the fourth phase.
// RULE10 - A wake-up caused by the watchdog clears the time out flag.
// RULE11 - Subtract with borrow computes acc minus file minus inverted carry to the destination.
// RULE12 - Subtract with borrow updates N, OV, C, DC and Z from its result.
// RULE13 - Subtract with borrow writes the file register when the destination bit is 1.
// RULE14 - Each instruction is one word, one cycle of decode, read, process and write phases.
// RULE15 - In subtraction carry is set with no borrow and cleared on a borrow.
module rssx_exec #(
	parameter logic [7:0] ACCESS_SPLIT = 8'h80,
	parameter logic [3:0] ACCESS_HIGH_BANK = 4'hf
) (
	input wire logic clock_in,
	input wire logic rst_in,
	input wire logic [15:0] instr_in,
	input wire logic instr_valid_in,
	input wire logic [3:0] bank_select_reg_in,
	input wire logic ext_set_enable_in,
	input wire logic [11:0] index_base_in,
	input wire logic [7:0] mem_rdata_in,
	input wire logic wake_in,
	input wire logic wake_by_wdt_in,
	output logic [11:0] mem_addr_out,
	output logic mem_rd_en_out,
	output logic mem_wr_en_out,
	output logic [7:0] mem_wdata_out,
	output logic [7:0] acc_out,
	output logic carry_flag_out,
	output logic digit_carry_flag_out,
	output logic zero_flag_out,
	output logic overflow_flag_out,
	output logic negative_flag_out,
	output logic power_down_flag_out,
	output logic time_out_flag_out,
	output logic watchdog_clear_out,
	output logic [7:0] watchdog_counter_clear_value_out,
	output logic asleep_out,
	output logic instr_done_out,
	output rssx_pkg::rssx_phase_t phase_out
);
	import rssx_pkg::*;

	rssx_state_t s_q;
	rssx_state_t s_d;
	rssx_phase_t phase;
	logic [7:0] f_addr;
	logic [11:0] dec_addr;
	rssx_opkind_t dec_kind;
	logic dec_sleep;
	logic [8:0] sub_full;
	logic [4:0] sub_low;
	logic [7:0] sub_res;
	logic [7:0] rot_res;

	// ----------------------------------------------------------------
	// Phase sequencer
	// ----------------------------------------------------------------
	rssx_phase_gen u_phase (
		.clock_in(clock_in),
		.rst_in(rst_in),
		.run_in(!s_q.asleep), // RULE9
		.phase_out(phase)
	);

	// ----------------------------------------------------------------
	// Decode and address formation
	// ----------------------------------------------------------------
	always_comb begin
		f_addr = instr_in[7:0];
		dec_kind = OPK_NONE;
		dec_sleep = 1'b0;
		if (instr_in[15:10] == OP_ROTATE_RIGHT_NO_CARRY) begin
			dec_kind = OPK_ROTATE; // RULE1
		end else if (instr_in[15:9] == OP_SET_ALL_ONES) begin
			dec_kind = OPK_SET; // RULE6
		end else if (instr_in[15:10] == OP_SUBTRACT_REG_FROM_ACC_BORROW) begin
			dec_kind = OPK_SUBTRACT; // RULE11
		end else if (instr_in == OP_SLEEP) begin
			dec_sleep = 1'b1; // RULE7
		end
		if (instr_in[BANK_BIT]) begin
			dec_addr = {bank_select_reg_in, f_addr}; // RULE4
		end else if (ext_set_enable_in && (f_addr <= INDEXED_LIMIT)) begin
			dec_addr = index_base_in + {4'h0, f_addr}; // RULE5
		end else if (f_addr < ACCESS_SPLIT) begin
			dec_addr = {4'h0, f_addr}; // RULE3
		end else begin
			dec_addr = {ACCESS_HIGH_BANK, f_addr}; // RULE3
		end
	end

	// ----------------------------------------------------------------
	// Data path
	// ----------------------------------------------------------------
	always_comb begin
		rot_res = {mem_rdata_in[0], mem_rdata_in[7:1]}; // RULE1
		sub_full = {1'b0, s_q.acc} + {1'b0, ~mem_rdata_in} + {8'h00, s_q.carry}; // RULE11
		sub_low = {1'b0, s_q.acc[3:0]} + {1'b0, ~mem_rdata_in[3:0]} + {4'h0, s_q.carry};
		sub_res = sub_full[7:0];
	end

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	always_comb begin
		s_d = s_q;
		s_d.rd_en = 1'b0;
		s_d.wr_en = 1'b0;
		s_d.wd_clear = 1'b0;
		s_d.done = 1'b0;
		if (s_q.asleep) begin
			if (wake_in) begin
				s_d.asleep = 1'b0;
				if (wake_by_wdt_in) begin
					s_d.time_out = 1'b0; // RULE10
				end
			end
		end else begin
			unique case (phase)
				PH_DECODE: begin
					s_d.kind = OPK_NONE;
					s_d.is_sleep = 1'b0;
					if (instr_valid_in) begin
						s_d.kind = dec_kind; // RULE14
						s_d.is_sleep = dec_sleep;
						s_d.addr = dec_addr;
						s_d.dest_file = instr_in[DEST_BIT] || (dec_kind == OPK_SET);
						s_d.rd_en = (dec_kind != OPK_NONE);
					end
				end
				PH_READ: begin
				end
				PH_PROCESS: begin
					s_d.n_carry = s_q.carry;
					s_d.n_digit_carry = s_q.digit_carry;
					s_d.n_overflow = s_q.overflow;
					s_d.n_zero = s_q.zero;
					s_d.n_negative = s_q.negative;
					unique case (s_q.kind)
						OPK_ROTATE: begin
							s_d.result = rot_res;
							s_d.n_zero = (rot_res == 8'h00); // RULE1
							s_d.n_negative = rot_res[7];
						end
						OPK_SET: begin
							s_d.result = ALL_ONES; // RULE6
						end
						OPK_SUBTRACT: begin
							s_d.result = sub_res;
							s_d.n_carry = sub_full[8]; // RULE15
							s_d.n_digit_carry = sub_low[4]; // RULE12
							s_d.n_zero = (sub_res == 8'h00); // RULE12
							s_d.n_negative = sub_res[7]; // RULE12
							s_d.n_overflow = (s_q.acc[7] != mem_rdata_in[7])
								&& (sub_res[7] != s_q.acc[7]); // RULE12
						end
						OPK_NONE: begin
						end
					endcase
					s_d.wr_en = (s_q.kind != OPK_NONE) && s_q.dest_file; // RULE2 RULE13
					s_d.done = 1'b1;
				end
				PH_WRITE: begin
					if (s_q.kind != OPK_NONE) begin
						if (!s_q.dest_file) begin
							s_d.acc = s_q.result; // RULE2
						end
						s_d.carry = s_q.n_carry;
						s_d.digit_carry = s_q.n_digit_carry;
						s_d.zero = s_q.n_zero;
						s_d.overflow = s_q.n_overflow;
						s_d.negative = s_q.n_negative;
					end
					if (s_q.is_sleep) begin
						s_d.power_down = 1'b0; // RULE7
						s_d.time_out = 1'b1; // RULE7
						s_d.wd_clear = 1'b1; // RULE8
						s_d.asleep = 1'b1; // RULE9
					end
				end
			endcase
		end
	end

	always_ff @(posedge clock_in or posedge rst_in) begin
		if (rst_in) begin
			s_q <= '0;
			s_q.acc <= RST_ACC;
			s_q.power_down <= RST_POWER_DOWN_FLAG;
			s_q.time_out <= RST_TIME_OUT_FLAG;
		end else begin
			s_q <= s_d;
		end
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	assign mem_addr_out = s_q.addr;
	assign mem_rd_en_out = s_q.rd_en;
	assign mem_wr_en_out = s_q.wr_en;
	assign mem_wdata_out = s_q.result;
	assign acc_out = s_q.acc;
	assign carry_flag_out = s_q.carry;
	assign digit_carry_flag_out = s_q.digit_carry;
	assign zero_flag_out = s_q.zero;
	assign overflow_flag_out = s_q.overflow;
	assign negative_flag_out = s_q.negative;
	assign power_down_flag_out = s_q.power_down;
	assign time_out_flag_out = s_q.time_out;
	assign watchdog_clear_out = s_q.wd_clear; // RULE8
	assign watchdog_counter_clear_value_out = WATCHDOG_CLEAR_VALUE;
	assign asleep_out = s_q.asleep;
	assign instr_done_out = s_q.done;
	assign phase_out = phase;

endmodule

`default_nettype wire

//--- rtl/rssx_pkg.sv
/*
 * Package for the rotate/set/sleep/subtract execution block:
 * opcode patterns, phase codes, reset values and the register state.
 * Assumes a single clock domain and one clock per quarter-phase.
 */
`default_nettype none

package rssx_pkg;

	// ----------------------------------------------------------------
	// Opcode patterns
	// ----------------------------------------------------------------
	localparam logic [5:0] OP_ROTATE_RIGHT_NO_CARRY = 6'h10;
	localparam logic [6:0] OP_SET_ALL_ONES = 7'h34;
	localparam logic [5:0] OP_SUBTRACT_REG_FROM_ACC_BORROW = 6'h15;
	localparam logic [15:0] OP_SLEEP = 16'h0003;
	localparam logic [7:0] INDEXED_LIMIT = 8'h5f;
	localparam logic [7:0] ALL_ONES = 8'hff;
	localparam logic [7:0] WATCHDOG_CLEAR_VALUE = 8'h00;

	// ----------------------------------------------------------------
	// Field positions
	// ----------------------------------------------------------------
	localparam int DEST_BIT = 9;
	localparam int BANK_BIT = 8;

	// ----------------------------------------------------------------
	// Reset values
	// ----------------------------------------------------------------
	localparam logic RST_POWER_DOWN_FLAG = 1'h1;
	localparam logic RST_TIME_OUT_FLAG = 1'h1;
	localparam logic [7:0] RST_ACC = 8'h00;

	// ----------------------------------------------------------------
	// Quarter-phases of the instruction cycle
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		PH_DECODE = 2'b00,
		PH_READ = 2'b01,
		PH_PROCESS = 2'b10,
		PH_WRITE = 2'b11
	} rssx_phase_t;

	typedef enum logic [1:0] {
		OPK_NONE = 2'b00,
		OPK_ROTATE = 2'b01,
		OPK_SET = 2'b10,
		OPK_SUBTRACT = 2'b11
	} rssx_opkind_t;

	typedef struct packed {
		rssx_phase_t phase;
	} rssx_phase_state_t;

	typedef struct packed {
		rssx_opkind_t kind;
		logic is_sleep;
		logic dest_file;
		logic [11:0] addr;
		logic [7:0] result;
		logic [7:0] acc;
		logic carry;
		logic digit_carry;
		logic zero;
		logic overflow;
		logic negative;
		logic n_carry;
		logic n_digit_carry;
		logic n_zero;
		logic n_overflow;
		logic n_negative;
		logic power_down;
		logic time_out;
		logic asleep;
		logic rd_en;
		logic wr_en;
		logic wd_clear;
		logic done;
	} rssx_state_t;

endpackage

`default_nettype wire

//--- rtl/rssx_phase_gen.sv
/*
 * Four quarter-phase sequencer of the instruction cycle.
 * Assumes run_in is low while the oscillator is stopped in sleep.
 */
`default_nettype none

module rssx_phase_gen (
	input wire logic clock_in,
	input wire logic rst_in,
	input wire logic run_in,
	output rssx_pkg::rssx_phase_t phase_out
);
	import rssx_pkg::*;

	rssx_phase_state_t s_q;
	rssx_phase_state_t s_d;

	// ----------------------------------------------------------------
	// Phase advance
	// ----------------------------------------------------------------
	always_comb begin
		s_d = s_q;
		if (run_in) begin
			s_d.phase = rssx_phase_t'(s_q.phase + 2'h1); // RULE14
		end
	end

	always_ff @(posedge clock_in or posedge rst_in) begin
		if (rst_in) begin
			s_q <= '{phase: PH_DECODE};
		end else begin
			s_q <= s_d;
		end
	end

	assign phase_out = s_q.phase;

endmodule

`default_nettype wire

//--- bench/rssx_exec_properties.sv
/* Port checker for rssx_exec.
   Bound to every rssx_exec instance. */
`default_nettype none
module rssx_exec_properties
	import rssx_pkg::*;
(
	input wire logic clock_in,
	input wire logic rst_in,
	input wire logic [15:0] instr_in,
	input wire logic instr_valid_in,
	input wire logic [3:0] bank_select_reg_in,
	input wire logic wake_in,
	input wire logic wake_by_wdt_in,
	input wire logic [11:0] mem_addr_out,
	input wire logic mem_rd_en_out,
	input wire logic mem_wr_en_out,
	input wire logic [7:0] mem_wdata_out,
	input wire logic power_down_flag_out,
	input wire logic time_out_flag_out,
	input wire logic watchdog_clear_out,
	input wire logic [7:0] watchdog_counter_clear_value_out,
	input wire logic asleep_out,
	input wire logic instr_done_out,
	input wire logic [1:0] phase_out
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge clock_in); endclocking
	default disable iff (rst_in);
	wire take = phase_out == PH_DECODE && instr_valid_in && !asleep_out;
	chk_read_phase: assert property (mem_rd_en_out |-> phase_out == PH_READ)
		else $error("read strobe off phase");
	chk_write_phase: assert property (mem_wr_en_out |->
		phase_out == PH_WRITE && instr_done_out) else $error("write strobe off phase");
	chk_sleep_watchdog: assert property ($rose(asleep_out) |->
		watchdog_clear_out && watchdog_counter_clear_value_out == WATCHDOG_CLEAR_VALUE)
		else $error("watchdog not cleared");
	chk_sleep_flags: assert property ($rose(asleep_out) |->
		!power_down_flag_out && time_out_flag_out) else $error("sleep flags wrong");
	chk_asleep_idle: assert property (asleep_out |->
		phase_out == PH_DECODE && !mem_rd_en_out) else $error("activity while asleep");
	chk_set_ones: assert property (take && instr_in[15:9] == OP_SET_ALL_ONES |-> ##3
		mem_wr_en_out && mem_wdata_out == ALL_ONES) else $error("set not written");
	chk_bank_addr: assert property (take && instr_in[BANK_BIT] &&
		instr_in[15:10] == OP_ROTATE_RIGHT_NO_CARRY |-> ##1 mem_rd_en_out &&
		mem_addr_out == {$past(bank_select_reg_in), $past(instr_in[7:0])})
		else $error("banked address wrong");
	chk_wake_wdt: assert property (asleep_out && wake_in && wake_by_wdt_in |=>
		!asleep_out && !time_out_flag_out) else $error("watchdog wake wrong");
endmodule
bind rssx_exec rssx_exec_properties chk (.clock_in, .rst_in, .instr_in, .instr_valid_in,
	.bank_select_reg_in, .wake_in, .wake_by_wdt_in, .mem_addr_out, .mem_rd_en_out,
	.mem_wr_en_out, .mem_wdata_out, .power_down_flag_out, .time_out_flag_out,
	.watchdog_clear_out, .watchdog_counter_clear_value_out, .asleep_out, .instr_done_out,
	.phase_out);
`default_nettype wire

//--- bench/rssx_mem_model.sv
/* Data memory facing rssx_exec.
   Read data follows one cycle after the strobe. */
`default_nettype none
module rssx_mem_model (
	input wire logic clock_in,
	input wire logic [11:0] mem_addr_out,
	input wire logic mem_rd_en_out,
	input wire logic mem_wr_en_out,
	input wire logic [7:0] mem_wdata_out,
	output logic [7:0] mem_rdata_in
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] cells [4096];
	always @(posedge clock_in) begin
		// Toggles outside reads so stale data never looks valid
		mem_rdata_in <= mem_rd_en_out ? cells[mem_addr_out] : ~mem_rdata_in;
		if (mem_wr_en_out) cells[mem_addr_out] <= mem_wdata_out;
	end
endmodule
`default_nettype wire

//--- bench/rssx_exec_tb.sv
/* Self-checking bench for rssx_exec.
   Assumes rssx_mem_model and the checker bind. */
`default_nettype none
module rssx_exec_tb;
	timeunit 1ns;
	timeprecision 1ps;
	import rssx_pkg::*;
	logic clock_in = 0, rst_in = 1, instr_valid_in = 0, ext_set_enable_in = 0;
	logic wake_in = 0, wake_by_wdt_in = 0, mem_rd_en_out, mem_wr_en_out;
	logic carry_flag_out, digit_carry_flag_out, zero_flag_out, overflow_flag_out;
	logic negative_flag_out, power_down_flag_out, time_out_flag_out, watchdog_clear_out;
	logic asleep_out, instr_done_out;
	logic [15:0] instr_in = 0;
	logic [3:0] bank_select_reg_in = 0;
	logic [11:0] index_base_in = 0, mem_addr_out;
	logic [7:0] mem_rdata_in, mem_wdata_out, acc_out, watchdog_counter_clear_value_out;
	rssx_phase_t phase_out;
	logic [31:0] lfsr = 32'he541;
	logic [7:0] w = 0;
	logic c = 0, dc = 0, z = 0, ov = 0, n = 0;
	logic [7:0] hi [8] = '{8'h40, 8'h43, 8'h68, 8'h69, 8'h55, 8'h56, 8'h54, 8'hff};
	int miscompares = 0, n_checks = 0;
	rssx_exec uut (.clock_in, .rst_in, .instr_in, .instr_valid_in, .bank_select_reg_in,
		.ext_set_enable_in, .index_base_in, .mem_rdata_in, .wake_in, .wake_by_wdt_in,
		.mem_addr_out, .mem_rd_en_out, .mem_wr_en_out, .mem_wdata_out, .acc_out,
		.carry_flag_out, .digit_carry_flag_out, .zero_flag_out, .overflow_flag_out,
		.negative_flag_out, .power_down_flag_out, .time_out_flag_out, .watchdog_clear_out,
		.watchdog_counter_clear_value_out, .asleep_out, .instr_done_out, .phase_out);
	rssx_mem_model mem (.clock_in, .mem_addr_out, .mem_rd_en_out, .mem_wr_en_out,
		.mem_wdata_out, .mem_rdata_in);
	initial forever #4 clock_in = ~clock_in;
	function automatic logic [31:0] next_rand(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	task automatic chk(input string what, input logic [19:0] exp, got);
		n_checks++;
		if (got !== exp) begin
			miscompares++;
			$display("FAIL %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", n_checks, miscompares);
		if (miscompares == 0 && n_checks > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask
	task automatic to_decode;
		do @(negedge clock_in); while (phase_out !== PH_WRITE);
		@(posedge clock_in);
	endtask
	task automatic exec(input logic [15:0] ins, input logic [7:0] fv);
		logic [8:0] s;
		logic [7:0] f, r;
		logic [11:0] ea;
		logic rot, set, sub, wr;
		f = ins[7:0];
		rot = ins[15:10] == OP_ROTATE_RIGHT_NO_CARRY;
		set = ins[15:9] == OP_SET_ALL_ONES;
		sub = ins[15:10] == OP_SUBTRACT_REG_FROM_ACC_BORROW;
		lfsr = next_rand(lfsr);
		to_decode();
		instr_in <= ins;
		instr_valid_in <= 1;
		bank_select_reg_in <= lfsr[3:0];
		ext_set_enable_in <= lfsr[4];
		index_base_in <= lfsr[31:20];
		@(negedge clock_in);
		ea = ins[BANK_BIT] ? {bank_select_reg_in, f} :
			(ext_set_enable_in && f <= INDEXED_LIMIT) ? index_base_in + f :
			f < 8'h80 ? {4'h0, f} : {4'hf, f};
		mem.cells[ea] = fv;
		@(posedge clock_in);
		instr_valid_in <= 0;
		r = rot ? {fv[0], fv[7:1]} : ALL_ONES;
		s = {1'b0, w} + {1'b0, ~fv} + c;
		if (sub) r = s[7:0];
		wr = set || ((rot || sub) && ins[DEST_BIT]);
		do @(negedge clock_in); while (phase_out !== PH_WRITE);
		chk("wr", wr, mem_wr_en_out);
		chk("done", 1'b1, instr_done_out);
		if (rot || set || sub) chk("addr", ea, mem_addr_out);
		if (wr) chk("data", r, mem_wdata_out);
		if (sub) begin
			ov = (w[7] != fv[7]) && (r[7] != w[7]);
			dc = ({1'b0, w[3:0]} + {1'b0, ~fv[3:0]} + c) > 5'h0f;
			c = s[8];
		end
		if (rot || sub) begin
			if (!ins[DEST_BIT]) w = r;
			n = r[7];
			z = r == 8'h00;
		end
		@(negedge clock_in);
		chk("flags", {w, c, dc, z, ov, n}, {acc_out, carry_flag_out, digit_carry_flag_out,
			zero_flag_out, overflow_flag_out, negative_flag_out});
		$display("test %h done", ins);
	endtask
	task automatic sleep_wake(input logic by_wdt);
		to_decode();
		instr_in <= OP_SLEEP;
		instr_valid_in <= 1;
		repeat (5) @(negedge clock_in);
		chk("sleep", 3'b101, {asleep_out, power_down_flag_out, time_out_flag_out});
		repeat (3) @(negedge clock_in);
		chk("asleep", 1'b1, asleep_out);
		@(posedge clock_in);
		instr_valid_in <= 0;
		wake_in <= 1;
		wake_by_wdt_in <= by_wdt;
		@(posedge clock_in);
		wake_in <= 0;
		@(negedge clock_in);
		chk("wake", {1'b0, ~by_wdt}, {asleep_out, time_out_flag_out});
		$display("sleep test done");
	endtask
	initial begin
		repeat (2) @(posedge clock_in);
		rst_in <= 0;
		for (int i = 0; i < 48; i++) begin
			lfsr = next_rand(lfsr);
			exec({hi[i % 8], lfsr[15:8]}, lfsr[7:0]);
		end
		sleep_wake(1);
		sleep_wake(0);
		exec(16'h4300, 8'h01);
		tally_and_finish();
	end
	initial begin
		#40000;
		miscompares++;
		tally_and_finish();
	end
endmodule
`default_nettype wire
